// *** rtl/tcs_sequencer.sv ***
// conversion sequencer with apb registers, scan, sleep and completion pin
// Behaviour
// [RULE_01] normal result uses two conversion cycles; late past 167.2ms is flagged
// [RULE_02] three-cycle result still does the full three cycles; limit 251ms
// [RULE_03] open-circuit option: 8ms test pulse and settle cycle, then two cycles
// [RULE_04] broken thermocouple in test cycle reports open-circuit fault in result
// [RULE_05] thermistor autorange: test current first, best current chosen, two more cycles
// [RULE_06] thermocouple with three-cycle cold junction takes three cycles
// [RULE_07] three-reading diode uses three ratioed currents; two-reading uses two
// [RULE_08] start command with channel 1..20 converts that channel
// [RULE_09] start command with channel 0 scans every masked channel
// [RULE_10] scan goes from highest channel down to lowest
// [RULE_11] completion pin low from start until all conversions finish
// [RULE_12] masked channel without assignment is skipped
// [RULE_13] each result lands in its channel's result location
// [RULE_14] writing 0x97 to command requests sleep on next chip-select rise
// [RULE_15] sleep ends on chip-select low or reset, then start-up begins
// [RULE_16] before every cycle reconfigure switches and wait about 1ms
// [RULE_17] extra settle equals delay byte times 100us, at most 25.5ms
// [RULE_18] scan mask holds one bit per channel over three locations
// [RULE_19] filter field: 0 both, 1 enhanced 60Hz, 2 enhanced 50Hz
// [RULE_20] units bit 3 selects Fahrenheit, clear means Celsius
// [RULE_21] host writes zero to all other global configuration bits
// [RULE_22] extra delay applies before every cycle, also within scans
// [RULE_23] start commands ignored while busy, accepted again once pin is high
`timescale 1ns/1ps
module tcs_sequencer
  import tcs_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = tcs_pkg::SETTLE_CYC,
  parameter int unsigned STEP_CYC = tcs_pkg::STEP_CYC,
  parameter int unsigned OC_CYC = tcs_pkg::OC_CYC,
  parameter int unsigned MAX2_CYC = tcs_pkg::MAX2_CYC,
  parameter int unsigned MAX3_CYC = tcs_pkg::MAX3_CYC
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [tcs_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input logic csN,
  output logic doneN,
  output logic sleepMode,
  output logic startUp,
  // analog front end
  output logic convStart,
  output logic [tcs_pkg::CH_W-1:0] convChan,
  output logic [1:0] convPhase,
  output logic [1:0] exciteSel,
  output logic testCurrent,
  output logic [1:0] filterSel,
  output logic fahrenheit,
  input logic convDone,
  input logic [23:0] convData,
  input logic convFault
);
  import tcs_pkg::*;

  if (OC_CYC < 1 || MAX2_CYC < 1 || MAX3_CYC < MAX2_CYC) begin : g_badTime
    $error("timing counts out of range");
  end

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] cmd_reg;
  logic [7:0] gcfg_reg;
  logic [3:0] maskHi_reg;
  logic [7:0] maskMid_reg;
  logic [7:0] maskLo_reg;
  logic [7:0] delay_reg;
  logic [7:0] chCfg_reg [1:NCH];
  logic [31:0] result_reg [1:NCH];

  tcs_state_t state_reg;
  logic [CH_W-1:0] chan_reg;
  logic [NCH:1] pending_reg;
  logic [1:0] nCyc_reg;
  logic ocFault_reg;
  logic late_reg;
  logic [23:0] lastData_reg;
  logic [31:0] elapsed_reg;
  logic [31:0] budget_reg;
  logic [31:0] ocCnt_reg;
  logic sleepPend_reg;
  logic booted_reg;
  logic csMeta_reg;
  logic csSync_reg;
  logic csPrev_reg;

  logic [IDX_W-1:0] idx;
  logic access;
  logic mapped;
  logic wrEn;
  logic cmdWrite;
  logic startReq;
  logic sleepReq;
  logic [NCH:1] maskVec;
  logic [NCH:1] assignedVec;
  logic [NCH:1] oneHot;
  logic pickFound;
  logic [CH_W-1:0] pickCh;
  logic tStart;
  logic tBusy;
  logic csRise;
  logic [7:0] curCfg;
  logic [1:0] curKind;
  logic isOcTest;

  function automatic logic inRange(input logic [IDX_W-1:0] i, input logic [IDX_W-1:0] base);
    return (i > base) && (i <= base + IDX_W'(NCH));
  endfunction : inRange

  function automatic logic [CH_W-1:0] idxCh(input logic [IDX_W-1:0] i,
                                           input logic [IDX_W-1:0] base);
    return CH_W'(i - base);
  endfunction : idxCh

  // larger test reading means higher resistance, so a lower current code is chosen
  function automatic logic [1:0] bestCurrent(input logic [23:0] d);
    if (d[22]) return 2'h0;
    if (d[19]) return 2'h1;
    return 2'h2;
  endfunction : bestCurrent

  assign idx = paddr[ADDR_W-1:2];
  assign access = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) &&
    (idx == IDX_CMD || idx == IDX_GCFG || idx == IDX_MASK_RSVD || idx == IDX_MASK_HI ||
     idx == IDX_MASK_MID || idx == IDX_MASK_LO || idx == IDX_STATUS || idx == IDX_DELAY ||
     inRange(idx, IDX_RES_BASE) || inRange(idx, IDX_CFG_BASE));
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign wrEn = access && pwrite && mapped;
  assign cmdWrite = wrEn && idx == IDX_CMD;
  assign startReq = cmdWrite && state_reg == S_IDLE && pwdata[CMD_START_BIT] && // RULE_23
    pwdata[6:5] == CMD_MODE_START && pwdata[4:0] <= CH_W'(NCH);
  assign sleepReq = cmdWrite && state_reg == S_IDLE && pwdata[7:0] == CMD_SLEEP; // RULE_14
  assign maskVec = {maskHi_reg, maskMid_reg, maskLo_reg}; // RULE_18
  assign filterSel = gcfg_reg[1:0]; // RULE_19
  assign fahrenheit = gcfg_reg[GCFG_UNITS_BIT]; // RULE_20

  always_comb begin
    for (int i = 1; i <= NCH; i++) begin
      assignedVec[i] = chCfg_reg[i][CFG_ASSIGNED];
      oneHot[i] = (pwdata[4:0] == CH_W'(i));
    end
  end

  // reserved and other global bits are kept as written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gcfg_reg <= GCFG_RESET;
      maskHi_reg <= 4'h0;
      maskMid_reg <= 8'h00;
      maskLo_reg <= 8'h00;
      delay_reg <= 8'h00;
      for (int i = 1; i <= NCH; i++) begin
        chCfg_reg[i] <= 8'h00;
      end
    end else if (wrEn) begin
      if (idx == IDX_GCFG) gcfg_reg <= pwdata[7:0];
      if (idx == IDX_MASK_HI) maskHi_reg <= pwdata[3:0];
      if (idx == IDX_MASK_MID) maskMid_reg <= pwdata[7:0];
      if (idx == IDX_MASK_LO) maskLo_reg <= pwdata[7:0];
      if (idx == IDX_DELAY) delay_reg <= pwdata[7:0];
      if (inRange(idx, IDX_CFG_BASE)) chCfg_reg[idxCh(idx, IDX_CFG_BASE)] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_reg <= 8'h00;
    end else if (startReq || sleepReq) begin
      cmd_reg <= pwdata[7:0];
    end
  end

  // read data captured in setup, so it stands through a zero-wait access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= 32'h0;
      if (idx == IDX_CMD) prdata <= {24'h0, cmd_reg};
      if (idx == IDX_GCFG) prdata <= {24'h0, gcfg_reg};
      if (idx == IDX_MASK_HI) prdata <= {28'h0, maskHi_reg};
      if (idx == IDX_MASK_MID) prdata <= {24'h0, maskMid_reg};
      if (idx == IDX_MASK_LO) prdata <= {24'h0, maskLo_reg};
      if (idx == IDX_DELAY) prdata <= {24'h0, delay_reg};
      if (idx == IDX_STATUS) begin
        prdata[ST_BUSY] <= !doneN;
        prdata[ST_ASLEEP] <= sleepMode;
        prdata[ST_SLEEP_PEND] <= sleepPend_reg;
      end
      if (inRange(idx, IDX_RES_BASE)) prdata <= result_reg[idxCh(idx, IDX_RES_BASE)]; // RULE_13
      if (inRange(idx, IDX_CFG_BASE)) prdata <= {24'h0, chCfg_reg[idxCh(idx, IDX_CFG_BASE)]};
      if (paddr[1:0] != 2'h0) prdata <= 32'h0;
    end
  end

  // ************************************************************
  // chip-select synchroniser
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csMeta_reg <= 1'b1;
      csSync_reg <= 1'b1;
      csPrev_reg <= 1'b1;
    end else begin
      csMeta_reg <= csN;
      csSync_reg <= csMeta_reg;
      csPrev_reg <= csSync_reg;
    end
  end
  assign csRise = csSync_reg && !csPrev_reg;

  // ************************************************************
  // sequencing
  // ************************************************************
  assign curCfg = chCfg_reg[chan_reg];
  assign curKind = curCfg[CFG_TYPE_LSB +: 2];
  assign isOcTest = curKind == SENS_TC && curCfg[CFG_OPT] && convPhase == 2'h0;
  assign tStart = (state_reg == S_PICK && pickFound) || // RULE_22
    (state_reg == S_CONVERT && convDone && convPhase != nCyc_reg - 2'h1);

  tcs_scan_pick #(.NCH(NCH), .CH_W(CH_W)) u_pick (
    .pending(pending_reg),
    .found(pickFound),
    .pickCh(pickCh)
  );

  tcs_settle_timer #(.BASE_CYC(SETTLE_CYC), .STEP_CYC(STEP_CYC)) u_settle (
    .clk(clk),
    .rst(rst),
    .start(tStart),
    .extraSteps(delay_reg),
    .busy(tBusy)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      chan_reg <= '0;
      pending_reg <= '0;
      nCyc_reg <= 2'h2;
      convPhase <= 2'h0;
      exciteSel <= 2'h0;
      convStart <= 1'b0;
      doneN <= 1'b1;
      ocFault_reg <= 1'b0;
      lastData_reg <= 24'h0;
      budget_reg <= 32'h0;
      sleepMode <= 1'b0;
    end else begin
      convStart <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (startReq) begin
            // a single channel with no assignment simply finds nothing
            pending_reg <= (pwdata[4:0] == '0) ? (maskVec & assignedVec) // RULE_09 RULE_12
                                               : (oneHot & assignedVec); // RULE_08
            doneN <= 1'b0; // RULE_11
            state_reg <= S_PICK;
          end else if (sleepPend_reg && csRise) begin
            sleepMode <= 1'b1; // RULE_14
            state_reg <= S_ASLEEP;
          end
        end
        S_PICK: begin
          if (pickFound) begin
            chan_reg <= pickCh; // RULE_10
            nCyc_reg <= tcs_cycles(chCfg_reg[pickCh]); // RULE_06 RULE_07
            budget_reg <= (tcs_cycles(chCfg_reg[pickCh]) == 2'h3) ? 32'(MAX3_CYC) // RULE_02
                                                                  : 32'(MAX2_CYC); // RULE_01
            convPhase <= 2'h0;
            exciteSel <= 2'h0;
            ocFault_reg <= 1'b0;
            state_reg <= S_SETTLE;
          end else begin
            doneN <= 1'b1; // RULE_11
            state_reg <= S_IDLE;
          end
        end
        S_SETTLE: begin
          if (!tBusy && !testCurrent) begin
            convStart <= 1'b1; // RULE_16
            state_reg <= S_CONVERT;
          end
        end
        S_CONVERT: begin
          if (convDone) begin
            lastData_reg <= convData;
            if (isOcTest && convFault) ocFault_reg <= 1'b1; // RULE_04
            if (curKind == SENS_THERM && curCfg[CFG_OPT] && convPhase == 2'h0) begin
              exciteSel <= bestCurrent(convData); // RULE_05
            end
            if (curKind == SENS_DIODE) exciteSel <= convPhase + 2'h1; // RULE_07
            if (convPhase == nCyc_reg - 2'h1) begin
              state_reg <= S_STORE;
            end else begin
              convPhase <= convPhase + 2'h1; // RULE_01 RULE_03
              state_reg <= S_SETTLE;
            end
          end
        end
        S_STORE: begin
          pending_reg[chan_reg] <= 1'b0;
          state_reg <= S_PICK;
        end
        S_ASLEEP: begin
          if (!csSync_reg) begin
            sleepMode <= 1'b0; // RULE_15
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end
  assign convChan = chan_reg;

  // result word: faults on top, valid marker, last reading below
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 1; i <= NCH; i++) begin
        result_reg[i] <= 32'h0;
      end
    end else if (state_reg == S_STORE) begin
      result_reg[chan_reg] <= {8'h00, lastData_reg}; // RULE_13
      result_reg[chan_reg][RES_VALID_BIT] <= 1'b1;
      result_reg[chan_reg][RES_OC_BIT] <= ocFault_reg; // RULE_04
      result_reg[chan_reg][RES_LATE_BIT] <= late_reg; // RULE_01 RULE_02
    end
  end

  // output-time watchdog per result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_reg <= 32'h0;
      late_reg <= 1'b0;
    end else if (state_reg == S_PICK) begin
      elapsed_reg <= 32'h0;
      late_reg <= 1'b0;
    end else if (state_reg == S_SETTLE || state_reg == S_CONVERT) begin
      elapsed_reg <= elapsed_reg + 32'h1;
      if (elapsed_reg >= budget_reg) late_reg <= 1'b1; // RULE_01 RULE_02
    end
  end

  // open-circuit test pulse runs inside the first settle window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ocCnt_reg <= 32'h0;
      testCurrent <= 1'b0;
    end else if (state_reg == S_PICK && pickFound && chCfg_reg[pickCh][CFG_OPT] &&
                 chCfg_reg[pickCh][CFG_TYPE_LSB +: 2] == SENS_TC) begin
      ocCnt_reg <= 32'(OC_CYC); // RULE_03
      testCurrent <= 1'b1;
    end else if (ocCnt_reg > 32'h1) begin
      ocCnt_reg <= ocCnt_reg - 32'h1;
    end else begin
      ocCnt_reg <= 32'h0;
      testCurrent <= 1'b0;
    end
  end

  // sleep request waits for the chip-select rise; start-up pulses after reset or wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepPend_reg <= 1'b0;
      booted_reg <= 1'b0;
      startUp <= 1'b0;
    end else begin
      booted_reg <= 1'b1;
      startUp <= !booted_reg || (state_reg == S_ASLEEP && !csSync_reg); // RULE_15
      if (sleepReq) sleepPend_reg <= 1'b1; // RULE_14
      else if (state_reg == S_IDLE && csRise) sleepPend_reg <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_pinLowWhileBusy;
    @(posedge clk) disable iff (rst)
    (state_reg inside {S_SETTLE, S_CONVERT, S_STORE}) |-> !doneN;
  endproperty
  a_pinLowWhileBusy: assert property (p_pinLowWhileBusy) else $error("done pin high while busy"); // RULE_11

  property p_busyIgnoresStart;
    @(posedge clk) disable iff (rst)
    (state_reg != S_IDLE && cmdWrite) |=> (pending_reg & ~$past(pending_reg)) == '0;
  endproperty
  a_busyIgnoresStart: assert property (p_busyIgnoresStart) else $error("start taken busy"); // RULE_23

  property p_onlyAssigned;
    @(posedge clk) disable iff (rst)
    convStart |-> chCfg_reg[chan_reg][CFG_ASSIGNED];
  endproperty
  a_onlyAssigned: assert property (p_onlyAssigned) else $error("unassigned channel converted"); // RULE_12

  property p_descending;
    @(posedge clk) disable iff (rst)
    (state_reg == S_STORE) ##1 (state_reg == S_PICK && pickFound) |-> pickCh < $past(chan_reg);
  endproperty
  a_descending: assert property (p_descending) else $error("scan order not descending"); // RULE_10

  property p_convertAfterSettle;
    @(posedge clk) disable iff (rst)
    convStart |-> $past(state_reg) == S_SETTLE && !$past(tBusy) && !$past(testCurrent);
  endproperty
  a_convertAfterSettle: assert property (p_convertAfterSettle) else $error("no settle"); // RULE_16

  property p_ocFaultStored;
    @(posedge clk) disable iff (rst)
    (state_reg == S_STORE && ocFault_reg) |=> result_reg[$past(chan_reg)][RES_OC_BIT];
  endproperty
  a_ocFaultStored: assert property (p_ocFaultStored) else $error("open fault not stored"); // RULE_04

  property p_sleepEntry;
    @(posedge clk) disable iff (rst)
    (state_reg == S_IDLE && !startReq && sleepPend_reg && csRise) |=>
      sleepMode && state_reg == S_ASLEEP;
  endproperty
  a_sleepEntry: assert property (p_sleepEntry) else $error("sleep not entered"); // RULE_14

  property p_wake;
    @(posedge clk) disable iff (rst)
    (state_reg == S_ASLEEP && !csSync_reg) |=> (state_reg == S_IDLE && startUp && !sleepMode);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on chip select low"); // RULE_15

  // conversion starts counted per result, apart from the phase counter
  logic [1:0] nConv_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nConv_reg <= 2'h0;
    end else if (state_reg == S_PICK) begin
      nConv_reg <= 2'h0;
    end else if (convStart) begin
      nConv_reg <= nConv_reg + 2'h1;
    end
  end

  property p_cycleCount;
    @(posedge clk) disable iff (rst)
    (state_reg == S_STORE) |-> nConv_reg == nCyc_reg;
  endproperty
  a_cycleCount: assert property (p_cycleCount) else $error("wrong cycle count"); // RULE_03
endmodule : tcs_sequencer

// *** include/tcs_pkg.sv ***
// shared constants, types and decoders of the temperature conversion sequencer
package tcs_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NCH = 20;
  localparam int CH_W = 5;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // ************************************************************
  // register indices (byte address = 4 * index)
  // ************************************************************
  localparam logic [IDX_W-1:0] IDX_CMD = 10'h000;
  localparam logic [IDX_W-1:0] IDX_GCFG = 10'h0F0;
  localparam logic [IDX_W-1:0] IDX_MASK_RSVD = 10'h0F4;
  localparam logic [IDX_W-1:0] IDX_MASK_HI = 10'h0F5;
  localparam logic [IDX_W-1:0] IDX_MASK_MID = 10'h0F6;
  localparam logic [IDX_W-1:0] IDX_MASK_LO = 10'h0F7;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0F8;
  localparam logic [IDX_W-1:0] IDX_DELAY = 10'h0FF;
  localparam logic [IDX_W-1:0] IDX_RES_BASE = 10'h010;
  localparam logic [IDX_W-1:0] IDX_CFG_BASE = 10'h100;

  // ************************************************************
  // fields and values
  // ************************************************************
  localparam logic [7:0] CMD_SLEEP = 8'h97;
  localparam int CMD_START_BIT = 7;
  localparam logic [1:0] CMD_MODE_START = 2'h0;
  localparam logic [1:0] FILT_BOTH = 2'h0;
  localparam logic [1:0] FILT_60 = 2'h1;
  localparam logic [1:0] FILT_50 = 2'h2;
  localparam int GCFG_UNITS_BIT = 3;
  localparam logic [7:0] GCFG_RESET = 8'h00;
  localparam int CFG_ASSIGNED = 0;
  localparam int CFG_TYPE_LSB = 1;
  localparam int CFG_OPT = 3;
  localparam int CFG_CJ3 = 4;
  localparam logic [1:0] SENS_TC = 2'h0;
  localparam logic [1:0] SENS_RTD = 2'h1;
  localparam logic [1:0] SENS_THERM = 2'h2;
  localparam logic [1:0] SENS_DIODE = 2'h3;
  localparam int RES_OC_BIT = 31;
  localparam int RES_LATE_BIT = 30;
  localparam int RES_VALID_BIT = 24;
  localparam int ST_BUSY = 0;
  localparam int ST_ASLEEP = 1;
  localparam int ST_SLEEP_PEND = 2;

  // ************************************************************
  // timing, times in microseconds at the clock rate
  // ************************************************************
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned T_SETTLE_US = 1000;
  localparam int unsigned T_STEP_US = 100;
  localparam int unsigned T_OC_US = 8000;
  localparam int unsigned T_MAX2_US = 167200;
  localparam int unsigned T_MAX3_US = 251000;
  localparam int unsigned SETTLE_CYC = T_SETTLE_US * CLK_MHZ;
  localparam int unsigned STEP_CYC = T_STEP_US * CLK_MHZ;
  localparam int unsigned OC_CYC = T_OC_US * CLK_MHZ;
  localparam int unsigned MAX2_CYC = T_MAX2_US * CLK_MHZ;
  localparam int unsigned MAX3_CYC = T_MAX3_US * CLK_MHZ;

  typedef enum logic [2:0] {
    S_IDLE, S_PICK, S_SETTLE, S_CONVERT, S_STORE, S_ASLEEP
  } tcs_state_t;

  // conversion cycles one result needs
  function automatic logic [1:0] tcs_cycles(input logic [7:0] cfg);
    logic [1:0] kind;
    kind = cfg[CFG_TYPE_LSB +: 2];
    if ((kind == SENS_TC && (cfg[CFG_OPT] || cfg[CFG_CJ3])) ||
        (kind == SENS_THERM && cfg[CFG_OPT]) || (kind == SENS_DIODE && cfg[CFG_OPT]))
      return 2'h3;
    return 2'h2;
  endfunction : tcs_cycles

endpackage : tcs_pkg

// *** rtl/tcs_scan_pick.sv ***
// picks the highest-numbered pending channel
`timescale 1ns/1ps
module tcs_scan_pick #(
  parameter int NCH = tcs_pkg::NCH,
  parameter int CH_W = tcs_pkg::CH_W
) (
  // pending channels
  input logic [NCH:1] pending,
  // choice
  output logic found,
  output logic [CH_W-1:0] pickCh
);
  if (NCH < 1 || NCH >= (1 << CH_W)) begin : g_badSize
    $error("channel count does not fit the channel field");
  end

  // ascending loop, so the last hit is the highest channel
  always_comb begin
    found = 1'b0;
    pickCh = '0;
    for (int i = 1; i <= NCH; i++) begin
      if (pending[i]) begin
        found = 1'b1;
        pickCh = CH_W'(i);
      end
    end
  end
endmodule : tcs_scan_pick

// *** rtl/tcs_settle_timer.sv ***
// settling delay: fixed part plus programmable steps
`timescale 1ns/1ps
module tcs_settle_timer #(
  parameter int unsigned BASE_CYC = tcs_pkg::SETTLE_CYC,
  parameter int unsigned STEP_CYC = tcs_pkg::STEP_CYC
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // control
  input logic start,
  input logic [7:0] extraSteps,
  output logic busy
);
  if (BASE_CYC < 1 || STEP_CYC < 1) begin : g_badTime
    $error("settling counts must be at least one cycle");
  end

  logic [31:0] cnt_reg;
  logic [31:0] load;

  assign load = 32'(BASE_CYC) + 32'(extraSteps) * 32'(STEP_CYC);
  assign busy = (cnt_reg != 32'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
    end else if (start) begin
      cnt_reg <= load; // RULE_17
    end else if (cnt_reg != 32'h0) begin
      cnt_reg <= cnt_reg - 32'h1;
    end
  end

  property p_loadDelay;
    @(posedge clk) disable iff (rst)
    start |=> cnt_reg == 32'(BASE_CYC) + 32'($past(extraSteps)) * 32'(STEP_CYC);
  endproperty
  a_loadDelay: assert property (p_loadDelay) else $error("settle delay loaded wrong"); // RULE_17

  property p_countsDown;
    @(posedge clk) disable iff (rst)
    (busy && !start) |=> cnt_reg == $past(cnt_reg) - 32'h1;
  endproperty
  a_countsDown: assert property (p_countsDown) else $error("settle count not falling"); // RULE_16
endmodule : tcs_settle_timer

// *** dv/tcs_afe_model.sv ***
// front-end model answering conversion cycles
`timescale 1ns/1ps
module tcs_afe_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // from sequencer and bench
  input wire logic convStart,
  input wire logic slow,
  input wire logic openLine,
  // answer
  output logic convDone,
  output logic [23:0] convData,
  output logic convFault
);
  logic [2:0] waitCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt <= 3'h0;
      convDone <= 1'h0;
    end else begin
      convDone <= (waitCnt == 3'h1);
      if (convStart)
        waitCnt <= slow ? 3'h7 : 3'h2;
      else if (waitCnt != 3'h0)
        waitCnt <= waitCnt - 3'h1;
    end
  end
  // reading only holds with the done pulse, toggles while counting, zero when idle
  assign convData = convDone ? 24'h012345 : {24{waitCnt[0]}};
  assign convFault = convDone & openLine;
endmodule : tcs_afe_model

// *** dv/tb.sv ***
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module tb;
  import tcs_pkg::*;
  logic clk, rst, psel, penable, pwrite, csN, slow, openLine, pready, pslverr;
  logic doneN, sleepMode, convStart, convDone, convFault, testCurrent, fahrenheit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] convChan;
  logic [4:0] seen [0:7];
  logic [1:0] filterSel;
  logic [23:0] convData;
  int n_errors, n_checks, nStarts;
  tcs_sequencer #(.SETTLE_CYC(20), .STEP_CYC(3), .OC_CYC(30), .MAX2_CYC(2000),
    .MAX3_CYC(3000)) dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .csN(csN), .doneN(doneN), .sleepMode(sleepMode), .startUp(),
    .convStart(convStart), .convChan(convChan), .convPhase(), .exciteSel(),
    .testCurrent(testCurrent), .filterSel(filterSel), .fahrenheit(fahrenheit),
    .convDone(convDone), .convData(convData), .convFault(convFault));
  tcs_afe_model afe_u (.clk(clk), .rst(rst), .convStart(convStart), .slow(slow),
    .openLine(openLine), .convDone(convDone), .convData(convData), .convFault(convFault));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // sampled mid-cycle so the registered channel has settled
  always @(negedge clk) if (convStart === 1'h1) begin
    seen[nStarts[2:0]] = convChan;
    nStarts++;
  end
  // ****
  // shared tasks
  // ****
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] v, input logic [31:0] e);
    n_checks++;
    if (v !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, v);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    if (i == 50) begin
      n_errors++;
      finish_test();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wait_sig(input bit slp, input logic v);
    int i;
    for (i = 0; i < 3000 && (slp ? sleepMode : doneN) !== v; i++) @(posedge clk);
    if ((slp ? sleepMode : doneN) !== v) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_sig
  task automatic run(input logic [7:0] cmd);
    nStarts = 0;
    apb(1'h1, IDX_CMD, {24'h0, cmd});
  endtask : run
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    apb(1'h0, IDX_GCFG, 32'h0);
    check("gcfg reset", rd, 32'h0);
    apb(1'h1, IDX_GCFG, 32'h9);
    check("filter 60", {30'h0, filterSel}, {30'h0, FILT_60});
    check("units", {31'h0, fahrenheit}, 32'h1);
    apb(1'h1, IDX_GCFG, 32'h2);
    check("filter 50", {30'h0, filterSel}, {30'h0, FILT_50});
    apb(1'h0, IDX_MASK_RSVD, 32'h0);
    check("mask reserved", rd, 32'h0);
  endtask : t_regs
  task automatic t_single();
    apb(1'h1, IDX_CFG_BASE + 10'h5, 32'h1);
    apb(1'h1, IDX_CFG_BASE + 10'h3, 32'h1);
    run(8'h85);
    check("done low", {31'h0, doneN}, 32'h0);
    apb(1'h1, IDX_CMD, 32'h83);
    wait_sig(1'h0, 1'h1);
    check("cycles", nStarts, 2);
    check("busy start", {27'h0, seen[1]}, 32'h5);
    apb(1'h0, IDX_RES_BASE + 10'h5, 32'h0);
    check("result", rd, 32'h01012345);
  endtask : t_single
  task automatic t_scan();
    apb(1'h1, IDX_MASK_HI, 32'hC);
    apb(1'h1, IDX_MASK_MID, 32'h80);
    apb(1'h1, IDX_MASK_LO, 32'h1);
    apb(1'h1, IDX_DELAY, 32'h2);
    apb(1'h1, IDX_CFG_BASE + 10'h14, 32'h1);
    apb(1'h1, IDX_CFG_BASE + 10'h10, 32'h1);
    apb(1'h1, IDX_CFG_BASE + 10'h1, 32'h1);
    run(8'h80);
    wait_sig(1'h0, 1'h1);
    check("scan cycles", nStarts, 6);
    check("first", {27'h0, seen[0]}, 32'h14);
    check("second", {27'h0, seen[2]}, 32'h10);
    check("last", {27'h0, seen[4]}, 32'h1);
  endtask : t_scan
  task automatic t_open();
    openLine <= 1'h1;
    slow <= 1'h1;
    apb(1'h1, IDX_CFG_BASE + 10'h7, 32'h9);
    run(8'h87);
    @(posedge clk);
    check("oc pulse", {31'h0, testCurrent}, 32'h1);
    wait_sig(1'h0, 1'h1);
    check("oc cycles", nStarts, 3);
    apb(1'h0, IDX_RES_BASE + 10'h7, 32'h0);
    check("oc result", rd, 32'h81012345);
    apb(1'h1, IDX_CFG_BASE + 10'h9, 32'hF);
    run(8'h89);
    wait_sig(1'h0, 1'h1);
    check("diode cycles", nStarts, 3);
    apb(1'h1, IDX_CFG_BASE + 10'hA, 32'hD);
    run(8'h8A);
    wait_sig(1'h0, 1'h1);
    check("autorange cycles", nStarts, 3);
  endtask : t_open
  task automatic t_sleep();
    apb(1'h1, IDX_CMD, {24'h0, CMD_SLEEP});
    csN <= 1'h0;
    repeat (4) @(posedge clk);
    csN <= 1'h1;
    wait_sig(1'h1, 1'h1);
    check("asleep", {31'h0, sleepMode}, 32'h1);
    csN <= 1'h0;
    wait_sig(1'h1, 1'h0);
    check("awake", {31'h0, sleepMode}, 32'h0);
  endtask : t_sleep
  initial begin
    {rst, psel, penable, pwrite, csN, slow, openLine} = 7'h45;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_single();
    t_scan();
    t_open();
    t_sleep();
    finish_test();
  end
endmodule : tb
